/* File: pfm_regs.vh */
// register map, field codes and timing constants of the pulse frequency meter
`ifndef PFM_REGS_VH
`define PFM_REGS_VH
// ****************************************************************
// register offsets
// ****************************************************************
`define PFM_A_CTRL 4'h0
`define PFM_A_INPUT_SOURCE_PARAM 4'h1
`define PFM_A_FLO 4'h2
`define PFM_A_FHI 4'h3
`define PFM_A_DP 4'h4
`define PFM_A_DLO 4'h5
`define PFM_A_DHI 4'h6
`define PFM_A_LIM 4'h7
`define PFM_A_FILTER_TIME 4'h8
`define PFM_A_DIV 4'h9
`define PFM_A_FREQUENCY_MODE 4'hA
`define PFM_A_DISP 4'hB
`define PFM_A_STAT 4'hC
// ****************************************************************
// field codes
// ****************************************************************
`define PFM_TYPE_FREQUENCY_MODE 2'h0
`define PFM_TYPE_RPM 2'h1
`define PFM_TYPE_OTHER 2'h2
`define PFM_SRC_LOGIC 2'h0
`define PFM_SRC_SINK 2'h1
`define PFM_SRC_SOURCE 2'h2
`define PFM_LIM_OFF 2'h0
`define PFM_LIM_ERR 2'h1
`define PFM_LIM_CLAMP 2'h2
`define PFM_DP_MAX 2'h3
`define PFM_FILTER_TIME_MIN 8'h01
`define PFM_FILTER_TIME_MAX 8'hC8
`define PFM_DIV_MIN 16'h0001
// ****************************************************************
// reset values
// ****************************************************************
`define PFM_RST_FLO 16'h0000
`define PFM_RST_FHI 16'h2710
`define PFM_RST_DLO 16'h0000
`define PFM_RST_DHI 16'h2710
`define PFM_RST_FILTER_TIME 8'h01
`define PFM_RST_DIV 16'h0001
// ****************************************************************
// measurement constants
// ****************************************************************
`define PFM_CLK_HZ 10000000
`define PFM_GATE_MS 1000
`define PFM_GATE_CYC (`PFM_CLK_HZ / 1000 * `PFM_GATE_MS)
`define PFM_FMAX_HZ 32'h0000_2710
`define PFM_FILTER_TIME_TICK_MS 10
`define PFM_FILTER_TIME_TICK_CYC (`PFM_CLK_HZ / 1000 * `PFM_FILTER_TIME_TICK_MS)
`define PFM_DISP_MAX 32'h0000_270F
`define PFM_SEC_PER_MIN 32'h0000_003C
`define PFM_ERR1 16'hE001
`define PFM_ERR_LIM 16'hE000
// ****************************************************************
// menu display codes
// ****************************************************************
`define PFM_M_INP 4'h0
`define PFM_M_INPUT_SOURCE_PARAM 4'h1
`define PFM_M_FLO 4'h2
`define PFM_M_FHI 4'h3
`define PFM_M_DP 4'h4
`define PFM_M_DLO 4'h5
`define PFM_M_DHI 4'h6
`define PFM_M_LIM 4'h7
`define PFM_M_FILTER_TIME 4'h8
`define PFM_M_DIV 4'h9
`define PFM_M_OUTPUT_CONFIG_PARAM 4'hA
`endif

/* File: pfm_meter.v */
// pulse frequency / rotation speed meter with three-button setup menu
//
// Behaviour
// - setup is entered only from the input type prompt in frequency or rpm type, first advance shows input source.
// - next/prev step the value, advance confirms and shows the name, advance again moves on.
// - input source offers logic level, sinking contact with pull-up, sourcing with pull-down.
// - frequency order is source, low frequency_mode, high frequency_mode, decimal, low disp, high disp, limit, filter, output.
// - frequency maps linearly from the low/high bound to the low/high display value.
// - limit off keeps scaling outside the bounds up to the absolute maximum.
// - limit error shows an error outside the bounds.
// - limit clamp shows the low or high display value outside the bounds.
// - above the absolute maximum frequency the first over-range error is shown in every mode.
// - a first-order low-pass with time constant 0.01 to 2.00 s in 0.01 s steps smooths the value.
// - advance after the last parameter leaves setup and shows the output prompt.
// - rpm order is source, divisor, decimal, output; divisor set by next/prev.
// - rpm mode divides pulse rate by the divisor giving rotations per minute.
// - each decimal place raises resolution and lowers the limit, 9999 down to 9.999.
// - changing type, or source from the menu, resets the other settings to defaults.
`timescale 1ns/100ps
`include "pfm_regs.vh"
module pfm_meter (
   // clock, reset, enable
   input wire core_clk_i,
   input wire rst_n_i,
   input wire clk_en_i,
   // register port
   input wire [3:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   output reg [15:0] reg_rdata_o,
   // buttons, one-cycle pulses
   input wire btn_adv_i,
   input wire btn_next_i,
   input wire btn_prev_i,
   // pulse input
   input wire pulse_i,
   // display and source pin control
   output reg [15:0] disp_value_o,
   output reg [1:0] disp_dp_o,
   output reg disp_err_o,
   output reg [3:0] menu_item_o,
   output reg menu_name_o,
   output reg pullup_en_o,
   output reg pulldn_en_o
);
   // ****************************************************************
   // settings
   // ****************************************************************
   reg [1:0] type_r;
   reg [1:0] src_r;
   reg [15:0] flo_r, fhi_r, dlo_r, dhi_r, div_r;
   reg [1:0] dp_r, lim_r;
   reg [7:0] filter_time_r;
   reg [3:0] item_r;
   reg name_r;
   function [15:0] step16;
      input [15:0] v;
      input up;
      begin
         step16 = up ? v + 16'h0001 : v - 16'h0001;
      end
   endfunction
   function [1:0] step2;
      input [1:0] v;
      input up;
      input [1:0] top;
      begin
         if (up)
            step2 = (v == top) ? 2'h0 : v + 2'h1;
         else
            step2 = (v == 2'h0) ? top : v - 2'h1;
      end
   endfunction
   // next item after confirming the current one
   function [3:0] next_item;
      input [3:0] it;
      input [1:0] ty;
      begin
         case (it)
            `PFM_M_INP: next_item = `PFM_M_INPUT_SOURCE_PARAM;
            `PFM_M_INPUT_SOURCE_PARAM: next_item = (ty == `PFM_TYPE_RPM) ?
               `PFM_M_DIV : `PFM_M_FLO;
            `PFM_M_FLO: next_item = `PFM_M_FHI;
            `PFM_M_FHI: next_item = `PFM_M_DP;
            `PFM_M_DIV: next_item = `PFM_M_DP;
            `PFM_M_DP: next_item = (ty == `PFM_TYPE_RPM) ?
               `PFM_M_OUTPUT_CONFIG_PARAM : `PFM_M_DLO;
            `PFM_M_DLO: next_item = `PFM_M_DHI;
            `PFM_M_DHI: next_item = `PFM_M_LIM;
            `PFM_M_LIM: next_item = `PFM_M_FILTER_TIME;
            `PFM_M_FILTER_TIME: next_item = `PFM_M_OUTPUT_CONFIG_PARAM;
            default: next_item = it;
         endcase
      end
   endfunction
   wire step_up = btn_next_i;
   wire step_any = btn_next_i | btn_prev_i;
   wire in_setup = (type_r == `PFM_TYPE_FREQUENCY_MODE) | (type_r == `PFM_TYPE_RPM);
   // menu walk and settings; register writes share the same storage
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         type_r <= `PFM_TYPE_FREQUENCY_MODE;
         src_r <= `PFM_SRC_LOGIC;
         flo_r <= `PFM_RST_FLO;
         fhi_r <= `PFM_RST_FHI;
         dlo_r <= `PFM_RST_DLO;
         dhi_r <= `PFM_RST_DHI;
         div_r <= `PFM_RST_DIV;
         dp_r <= 2'h0;
         lim_r <= `PFM_LIM_OFF;
         filter_time_r <= `PFM_RST_FILTER_TIME;
         item_r <= `PFM_M_INP;
         name_r <= 1'b1;
      end else if (clk_en_i) begin
         if (btn_adv_i) begin
            if (item_r == `PFM_M_INP) begin
               if (in_setup) begin
                  item_r <= `PFM_M_INPUT_SOURCE_PARAM;
                  name_r <= 1'b1;
               end
            end else if (item_r != `PFM_M_OUTPUT_CONFIG_PARAM) begin
               if (!name_r)
                  name_r <= 1'b1; // confirm
               else
                  item_r <= next_item(item_r, type_r);
            end
         end else if (step_any && item_r != `PFM_M_INP &&
                      item_r != `PFM_M_OUTPUT_CONFIG_PARAM) begin
            name_r <= 1'b0;
            case (item_r)
               `PFM_M_INPUT_SOURCE_PARAM: begin
                  src_r <= step2(src_r, step_up, `PFM_SRC_SOURCE);
                  flo_r <= `PFM_RST_FLO;
                  fhi_r <= `PFM_RST_FHI;
                  dlo_r <= `PFM_RST_DLO;
                  dhi_r <= `PFM_RST_DHI;
                  div_r <= `PFM_RST_DIV;
                  dp_r <= 2'h0;
                  lim_r <= `PFM_LIM_OFF;
                  filter_time_r <= `PFM_RST_FILTER_TIME;
               end
               `PFM_M_FLO: flo_r <= step16(flo_r, step_up);
               `PFM_M_FHI: fhi_r <= step16(fhi_r, step_up);
               `PFM_M_DLO: dlo_r <= step16(dlo_r, step_up);
               `PFM_M_DHI: dhi_r <= step16(dhi_r, step_up);
               `PFM_M_DP: dp_r <= step2(dp_r, step_up, `PFM_DP_MAX);
               `PFM_M_LIM: lim_r <= step2(lim_r, step_up, `PFM_LIM_CLAMP);
               `PFM_M_FILTER_TIME:
                  if (step_up ? filter_time_r != `PFM_FILTER_TIME_MAX :
                      filter_time_r != `PFM_FILTER_TIME_MIN)
                     filter_time_r <= step_up ? filter_time_r + 8'h01 : filter_time_r - 8'h01;
               `PFM_M_DIV:
                  if (step_up || div_r != `PFM_DIV_MIN)
                     div_r <= step16(div_r, step_up);
               default: name_r <= 1'b1;
            endcase
         end else if (reg_wr_i) begin
            case (reg_addr_i)
               `PFM_A_CTRL: begin
                  if (reg_wdata_i[1:0] != type_r) begin
                     flo_r <= `PFM_RST_FLO;
                     fhi_r <= `PFM_RST_FHI;
                     dlo_r <= `PFM_RST_DLO;
                     dhi_r <= `PFM_RST_DHI;
                     div_r <= `PFM_RST_DIV;
                     dp_r <= 2'h0;
                     lim_r <= `PFM_LIM_OFF;
                     filter_time_r <= `PFM_RST_FILTER_TIME;
                     src_r <= `PFM_SRC_LOGIC;
                  end
                  type_r <= reg_wdata_i[1:0];
                  item_r <= `PFM_M_INP;
                  name_r <= 1'b1;
               end
               `PFM_A_INPUT_SOURCE_PARAM:
                  if (reg_wdata_i[1:0] <= `PFM_SRC_SOURCE)
                     src_r <= reg_wdata_i[1:0];
               `PFM_A_FLO: flo_r <= reg_wdata_i;
               `PFM_A_FHI: fhi_r <= reg_wdata_i;
               `PFM_A_DP: dp_r <= reg_wdata_i[1:0];
               `PFM_A_DLO: dlo_r <= reg_wdata_i;
               `PFM_A_DHI: dhi_r <= reg_wdata_i;
               `PFM_A_LIM:
                  if (reg_wdata_i[1:0] <= `PFM_LIM_CLAMP)
                     lim_r <= reg_wdata_i[1:0];
               `PFM_A_FILTER_TIME:
                  if (reg_wdata_i[7:0] >= `PFM_FILTER_TIME_MIN &&
                      reg_wdata_i[7:0] <= `PFM_FILTER_TIME_MAX)
                     filter_time_r <= reg_wdata_i[7:0];
               `PFM_A_DIV:
                  if (reg_wdata_i != 16'h0000)
                     div_r <= reg_wdata_i;
               default: item_r <= item_r;
            endcase
         end
      end
   end

   // ****************************************************************
   // frequency measurement over a one second gate
   // ****************************************************************
   // raw pulse used directly: no debounce, the source must be clean
   reg pulse_d_r;
   reg [23:0] gate_r;
   reg [15:0] cnt_r;
   reg [15:0] frequency_mode_r;
   reg ovr_r;
   reg new_r;
   wire gate_end = (gate_r == `PFM_GATE_CYC - 1);
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         pulse_d_r <= 1'b0;
         gate_r <= 24'h00_0000;
         cnt_r <= 16'h0000;
         frequency_mode_r <= 16'h0000;
         ovr_r <= 1'b0;
         new_r <= 1'b0;
      end else if (clk_en_i) begin
         pulse_d_r <= pulse_i;
         new_r <= gate_end;
         if (gate_end) begin
            gate_r <= 24'h00_0000;
            cnt_r <= 16'h0000;
            frequency_mode_r <= cnt_r;
            ovr_r <= ({16'h0000, cnt_r} > `PFM_FMAX_HZ);
         end else begin
            gate_r <= gate_r + 24'h00_0001;
            if (pulse_i && !pulse_d_r && cnt_r != 16'hFFFF)
               cnt_r <= cnt_r + 16'h0001;
         end
      end
   end

   // ****************************************************************
   // low-pass filter, updated every 10 ms
   // ****************************************************************
   // y += (x - y) / tau_steps; tau in 10 ms steps gives the time constant
   reg [16:0] tick_r;
   reg [31:0] filter_time_acc_r; // 16.16 fixed point
   wire tick = (tick_r == `PFM_FILTER_TIME_TICK_CYC - 1);
   wire [31:0] x_fx = {frequency_mode_r, 16'h0000};
   wire [31:0] diff = (x_fx >= filter_time_acc_r) ? x_fx - filter_time_acc_r :
                      filter_time_acc_r - x_fx;
   wire [31:0] dstep = diff / {24'h00_0000, filter_time_r};
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         tick_r <= 17'h0_0000;
         filter_time_acc_r <= 32'h0000_0000;
      end else if (clk_en_i) begin
         tick_r <= tick ? 17'h0_0000 : tick_r + 17'h0_0001;
         if (tick) begin
            if (x_fx >= filter_time_acc_r)
               filter_time_acc_r <= filter_time_acc_r + dstep;
            else
               filter_time_acc_r <= filter_time_acc_r - dstep;
         end
      end
   end
   wire [15:0] f_filter_time = filter_time_acc_r[31:16];
   // ****************************************************************
   // scaling and limit handling
   // ****************************************************************
   wire [31:0] fspan = {16'h0000, fhi_r} - {16'h0000, flo_r};
   wire below = f_filter_time < flo_r;
   wire above = f_filter_time > fhi_r;
   wire [31:0] fdel = below ? {16'h0000, flo_r - f_filter_time} :
                              {16'h0000, f_filter_time - flo_r};
   wire [31:0] dspan_u = (dhi_r >= dlo_r) ? {16'h0000, dhi_r - dlo_r} :
                                            {16'h0000, dlo_r - dhi_r};
   wire [31:0] prod = fdel * dspan_u;
   wire [31:0] quot = (fspan == 32'h0000_0000) ? 32'h0000_0000 :
                      prod / fspan;
   wire neg = below ^ (dhi_r < dlo_r);
   wire [15:0] lin = neg ? dlo_r - quot[15:0] : dlo_r + quot[15:0];

   // rpm: f * 60 * 10^dp / div
   function [31:0] pow10;
      input [1:0] p;
      begin
         case (p)
            2'h0: pow10 = 32'h0000_0001;
            2'h1: pow10 = 32'h0000_000A;
            2'h2: pow10 = 32'h0000_0064;
            default: pow10 = 32'h0000_03E8;
         endcase
      end
   endfunction
   wire [31:0] rpm_num = {16'h0000, f_filter_time} * `PFM_SEC_PER_MIN;
   wire [31:0] rpm = (rpm_num * pow10(dp_r)) / {16'h0000, div_r};
   wire rpm_ovr = rpm > `PFM_DISP_MAX;

   reg [15:0] val_nxt;
   reg err_nxt;
   always @* begin
      val_nxt = lin;
      err_nxt = 1'b0;
      if (ovr_r) begin
         val_nxt = `PFM_ERR1;
         err_nxt = 1'b1;
      end else if (type_r == `PFM_TYPE_RPM) begin
         if (rpm_ovr) begin
            val_nxt = `PFM_ERR1;
            err_nxt = 1'b1;
         end else
            val_nxt = rpm[15:0];
      end else if (below || above) begin
         case (lim_r)
            `PFM_LIM_ERR: begin
               val_nxt = `PFM_ERR_LIM;
               err_nxt = 1'b1;
            end
            `PFM_LIM_CLAMP: val_nxt = below ? dlo_r : dhi_r;
            default: val_nxt = lin;
         endcase
      end
   end

   // ****************************************************************
   // outputs and read port
   // ****************************************************************
   always @(posedge core_clk_i) begin
      if (!rst_n_i) begin
         disp_value_o <= 16'h0000;
         disp_dp_o <= 2'h0;
         disp_err_o <= 1'b0;
         menu_item_o <= `PFM_M_INP;
         menu_name_o <= 1'b1;
         pullup_en_o <= 1'b0;
         pulldn_en_o <= 1'b0;
         reg_rdata_o <= 16'h0000;
      end else if (clk_en_i) begin
         disp_value_o <= val_nxt;
         disp_dp_o <= dp_r;
         disp_err_o <= err_nxt;
         menu_item_o <= item_r;
         menu_name_o <= name_r;
         pullup_en_o <= (src_r == `PFM_SRC_SINK);
         pulldn_en_o <= (src_r == `PFM_SRC_SOURCE);
         reg_rdata_o <= 16'h0000;
         if (reg_rd_i) begin
            case (reg_addr_i)
               `PFM_A_CTRL: reg_rdata_o <= {14'h0000, type_r};
               `PFM_A_INPUT_SOURCE_PARAM: reg_rdata_o <= {14'h0000, src_r};
               `PFM_A_FLO: reg_rdata_o <= flo_r;
               `PFM_A_FHI: reg_rdata_o <= fhi_r;
               `PFM_A_DP: reg_rdata_o <= {14'h0000, dp_r};
               `PFM_A_DLO: reg_rdata_o <= dlo_r;
               `PFM_A_DHI: reg_rdata_o <= dhi_r;
               `PFM_A_LIM: reg_rdata_o <= {14'h0000, lim_r};
               `PFM_A_FILTER_TIME: reg_rdata_o <= {8'h00, filter_time_r};
               `PFM_A_DIV: reg_rdata_o <= div_r;
               `PFM_A_FREQUENCY_MODE: reg_rdata_o <= frequency_mode_r;
               `PFM_A_DISP: reg_rdata_o <= val_nxt;
               `PFM_A_STAT: reg_rdata_o <= {11'h000, new_r, ovr_r,
                                            err_nxt, name_r, 1'b0};
               default: reg_rdata_o <= 16'h0000;
            endcase
         end
      end
   end

endmodule

/* File: pfm_pulse_src.sv */
// pulse transmitter or switching contact model
`timescale 1ns/100ps
module pfm_pulse_src #(parameter HALF = 8) (
   // clock
   input wire core_clk_i,
   // source kind and pull enables
   input wire [1:0] kind_i,
   input wire pullup_en_i,
   input wire pulldn_en_i,
   // pulse line
   output reg pulse_o
);
   reg [7:0] cnt_r = 8'h00;
   reg act_r = 1'b0;
   initial pulse_o = 1'b0;
   always @(posedge core_clk_i) begin
      // clean toggles only, the pulse input has no debounce
      cnt_r <= (cnt_r == HALF - 1) ? 8'h00 : cnt_r + 8'h01;
      if (cnt_r == HALF - 1) begin
         act_r <= ~act_r;
      end
      // open contact floats unless the matching pull is on
      if (kind_i == 2'h0) begin
         pulse_o <= act_r;
      end else if (kind_i == 2'h1) begin
         pulse_o <= act_r ? 1'b0 : (pullup_en_i ? 1'b1 : ~pulse_o);
      end else begin
         pulse_o <= act_r ? 1'b1 : (pulldn_en_i ? 1'b0 : ~pulse_o);
      end
   end
endmodule

/* File: pfm_meter_chk.sv */
// port assertions of the pulse frequency meter
`timescale 1ns/100ps
module pfm_meter_chk (
   // clock and reset
   input wire core_clk_i,
   input wire rst_n_i,
   // watched inputs
   input wire reg_wr_i,
   input wire btn_adv_i,
   input wire btn_next_i,
   input wire btn_prev_i,
   // watched outputs
   input wire [15:0] disp_value_o,
   input wire disp_err_o,
   input wire [3:0] menu_item_o,
   input wire menu_name_o,
   input wire pullup_en_o,
   input wire pulldn_en_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   property p_pull_excl;
      !(pullup_en_o && pulldn_en_o);
   endproperty
   a_pull_excl: assert property (p_pull_excl)
      else $error("both pulls enabled");
   property p_err_code;
      disp_err_o |-> (disp_value_o == 16'hE001 || disp_value_o == 16'hE000);
   endproperty
   a_err_code: assert property (p_err_code)
      else $error("error flag without error code");
   property p_out_hold;
      menu_item_o == 4'hA && !reg_wr_i && !$past(reg_wr_i) |=>
         menu_item_o == 4'hA;
   endproperty
   a_out_hold: assert property (p_out_hold)
      else $error("output prompt left by a button");
   property p_item_move;
      $changed(menu_item_o) |->
         $past(btn_adv_i, 2) || $past(reg_wr_i, 2) || $past(reg_wr_i);
   endproperty
   a_item_move: assert property (p_item_move)
      else $error("menu item moved without advance");
   property p_name_rise;
      $rose(menu_name_o) |->
         $past(btn_adv_i, 2) || $past(reg_wr_i, 2) || $past(reg_wr_i);
   endproperty
   a_name_rise: assert property (p_name_rise)
      else $error("name shown without advance");
   property p_name_fall;
      $fell(menu_name_o) |-> $past(btn_next_i, 2) || $past(btn_prev_i, 2);
   endproperty
   a_name_fall: assert property (p_name_fall)
      else $error("editing without next or prev");
   property p_item0_name;
      menu_item_o == 4'h0 |-> menu_name_o;
   endproperty
   a_item0_name: assert property (p_item0_name)
      else $error("input type prompt not a name");
   property p_src_pull;
      $changed(pullup_en_o) |-> $past(btn_next_i, 2) ||
         $past(btn_prev_i, 2) || $past(reg_wr_i) || $past(reg_wr_i, 2);
   endproperty
   a_src_pull: assert property (p_src_pull)
      else $error("pull-up changed without a source change");
endmodule
bind pfm_meter pfm_meter_chk u_chk (.core_clk_i, .rst_n_i, .reg_wr_i,
   .btn_adv_i, .btn_next_i, .btn_prev_i, .disp_value_o, .disp_err_o,
   .menu_item_o, .menu_name_o, .pullup_en_o, .pulldn_en_o);

/* File: test_pulse_frequency_rpm_meter.sv */
// self-checking bench of the pulse frequency meter
`timescale 1ns/100ps
module test_pulse_frequency_rpm_meter;
   reg core_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1;
   reg [3:0] reg_addr_i = 4'h0;
   reg [15:0] reg_wdata_i = 16'h0000;
   reg reg_wr_i = 1'b0, reg_rd_i = 1'b0;
   reg btn_adv_i = 1'b0, btn_next_i = 1'b0, btn_prev_i = 1'b0;
   reg [1:0] src_kind = 2'h0;
   wire pulse_i, disp_err_o, menu_name_o, pullup_en_o, pulldn_en_o;
   wire [15:0] reg_rdata_o, disp_value_o;
   wire [1:0] disp_dp_o;
   wire [3:0] menu_item_o;
   integer n_mismatch = 0, tests_run = 0, i, a;
   integer m [0:9];
   integer fi [0:7] = '{2, 3, 4, 5, 6, 7, 8, 10};
   integer ri [0:3] = '{1, 9, 4, 10};
   reg [31:0] rs = 32'h0000_88ae;
   reg [15:0] d;
   pfm_meter DUT (.core_clk_i, .rst_n_i, .clk_en_i, .reg_addr_i,
      .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .btn_adv_i,
      .btn_next_i, .btn_prev_i, .pulse_i, .disp_value_o, .disp_dp_o,
      .disp_err_o, .menu_item_o, .menu_name_o, .pullup_en_o,
      .pulldn_en_o);
   pfm_pulse_src #(.HALF(8)) u_src (.core_clk_i, .kind_i(src_kind),
      .pullup_en_i(pullup_en_o), .pulldn_en_i(pulldn_en_o),
      .pulse_o(pulse_i));
   initial begin
      forever #50 core_clk_i = ~core_clk_i;
   end
   // ****************************************************************
   // tasks and behavioural model
   // ****************************************************************
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", tests_run, n_mismatch);
         if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
         end else begin
            $display("Some tests failed");
         end
         $finish;
      end
   endtask
   task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      begin
         tests_run = tests_run + 1;
         if (s !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %s expected %h seen %h", nm, e, s);
         end
      end
   endtask
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   // settings other than type (and source when kept) go to defaults
   task mdef(input integer s);
      begin
         m[1] = s;
         m[2] = 0;
         m[3] = 10000;
         m[4] = 0;
         m[5] = 0;
         m[6] = 10000;
         m[7] = 0;
         m[8] = 1;
         m[9] = 1;
      end
   endtask
   task m_wr(input integer a, input integer v);
      begin
         if (a == 0 && v != m[0]) begin
            m[0] = v;
            mdef(0);
         end
         if (a == 2 || a == 3 || a == 5 || a == 6) m[a] = v;
         if (a == 4 && v <= 3) m[4] = v;
         if (a == 7 && v <= 2) m[7] = v;
         if (a == 8 && v >= 1 && v <= 200) m[8] = v;
         if (a == 9 && v != 0) m[9] = v;
      end
   endtask
   task wr(input [3:0] a, input [15:0] v);
      begin
         @(posedge core_clk_i);
         reg_addr_i <= a;
         reg_wdata_i <= v;
         reg_wr_i <= 1'b1;
         @(posedge core_clk_i);
         reg_wr_i <= 1'b0;
         m_wr(a, v);
      end
   endtask
   task rdc(input [3:0] a, input [15:0] e);
      begin
         @(posedge core_clk_i);
         reg_addr_i <= a;
         reg_rd_i <= 1'b1;
         @(posedge core_clk_i);
         reg_rd_i <= 1'b0;
         #1;
         chk("reg", reg_rdata_o, e);
      end
   endtask
   task rall;
      begin
         for (i = 0; i < 10; i = i + 1) rdc(i, m[i]);
      end
   endtask
   // button pulse, then the two-edge menu latency passes
   task press(input integer b);
      begin
         @(posedge core_clk_i);
         btn_adv_i <= (b == 0);
         btn_next_i <= (b == 1);
         btn_prev_i <= (b == 2);
         @(posedge core_clk_i);
         btn_adv_i <= 1'b0;
         btn_next_i <= 1'b0;
         btn_prev_i <= 1'b0;
         repeat (3) @(posedge core_clk_i);
         #1;
      end
   endtask
   task item(input [3:0] e, input logic nm);
      begin
         chk("menu_item", {12'h000, menu_item_o}, {12'h000, e});
         chk("menu_name", {15'h0000, menu_name_o}, {15'h0000, nm});
      end
   endtask
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      #500000;
      n_mismatch = n_mismatch + 1;
      report_and_stop;
   end
   initial begin
      m[0] = 0;
      mdef(0);
      repeat (16) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      #1;
      item(4'h0, 1'b1);
      rall;
      rdc(4'hA, 16'h0000);
      rdc(4'hD, 16'h0000);
      wr(4'h0, 16'h0002);
      press(0);
      item(4'h0, 1'b1);
      wr(4'h0, 16'h0000);
      wr(4'h8, 16'h0000);
      wr(4'h8, 16'h00C9);
      wr(4'h9, 16'h0000);
      wr(4'h7, 16'h0003);
      rall;
      wr(4'h8, 16'h00C8);
      for (i = 0; i < 40; i = i + 1) begin
         rs = xs(rs);
         a = 2 + rs[2:0];
         d = rs[31:16];
         if (a == 4 || a == 7) d = d & 16'h0003;
         if (a == 8) d = d & 16'h00FF;
         wr(a, d);
      end
      rall;
      chk("dp", {14'h0000, disp_dp_o}, m[4]);
      // frozen clock enable: the advance press must be lost
      @(posedge core_clk_i);
      clk_en_i <= 1'b0;
      press(0);
      item(4'h0, 1'b1);
      clk_en_i <= 1'b1;
      press(0);
      item(4'h1, 1'b1);
      press(1);
      item(4'h1, 1'b0);
      chk("pullup", {15'h0000, pullup_en_o}, 16'h0001);
      press(1);
      chk("pulldn", {15'h0000, pulldn_en_o}, 16'h0001);
      press(2);
      chk("pullup", {15'h0000, pullup_en_o}, 16'h0001);
      press(0);
      item(4'h1, 1'b1);
      src_kind = 2'h1;
      mdef(1);
      rall;
      for (i = 0; i < 8; i = i + 1) begin
         press(0);
         item(fi[i], 1'b1);
         if (fi[i] == 8) begin
            press(1);
            press(0);
            m[8] = 2;
            rdc(4'h8, 16'h0002);
         end
      end
      press(1);
      press(0);
      item(4'hA, 1'b1);
      wr(4'h0, 16'h0001);
      src_kind = 2'h0;
      repeat (3) @(posedge core_clk_i);
      #1;
      item(4'h0, 1'b1);
      for (i = 0; i < 4; i = i + 1) begin
         press(0);
         item(ri[i], 1'b1);
         if (ri[i] == 9) begin
            press(1);
            press(0);
            m[9] = 2;
            rdc(4'h9, 16'h0002);
         end
      end
      rall;
      chk("disp", disp_value_o, 16'h0000);
      chk("err", {15'h0000, disp_err_o}, 16'h0000);
      report_and_stop;
   end
endmodule
